// *** wwr_supervisor.sv ***
// Wake-up generator, watchdog monitor and reset logic of a regulator.
// Assumes the kick and output-good inputs are asynchronous pins.
// Assumes BASE_CYC system clocks make one base unit of the timebase.
//
// Functional notes
// R1: Wake-up square wave runs continuously except while reset is asserted.
// R2: Wake-up wave has 50 percent duty, period fixed by base count.
// R3: Processor kicks watchdog after each wake-up rising edge.
// R4: First kick falling edge drives wake-up low until next cycle.
// R5: Further kicks in the same cycle are ignored.
// R6: A cycle ending with no kick produces a reset pulse.
// R7: Reset held low at power-up until output is good.
// R8: Reset asserted while output is below regulation limit.
// R9: Reset stays asserted while output remains out of regulation.
// R10: After cause clears, wait one reset delay, then release reset.
// R11: Wake-up output held low whenever reset is asserted.
// R12: After release, cycling restarts after the reset-to-wake delay.
// R13: Period, reset delay, reset-to-wake delay scale 8:1:4.
// R14: All intervals come from one tick counter of base units.
`timescale 1ns/100ps
module wwr_supervisor
  import wwr_pkg::*;
#(
  parameter int unsigned BASE_CYC = BASE_UNIT_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic watchdog_kick_input_i,
  input  wire logic regulated_output_good_i,
  output logic      wake_up_o,
  output logic      reset_n_o
);

  // Input synchronisers, three stages each.
  logic [2:0] kick_sync_r;
  logic [2:0] good_sync_r;
  logic       kick_lvl_r;
  logic       good_lvl_r;

  // A pin level counts only once stages two and three agree.
  wire kick_agree = (kick_sync_r[1] == kick_sync_r[2]);
  wire good_agree = (good_sync_r[1] == good_sync_r[2]);

  // Falling edge of the filtered kick level, one cycle wide.
  wire kick_fall  = kick_agree & kick_lvl_r & ~kick_sync_r[2];

  // The kick pin idles high, so its stages reset high to avoid a false edge.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kick_sync_r <= 3'h7;
    end else begin
      kick_sync_r <= {kick_sync_r[1:0], watchdog_kick_input_i};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kick_lvl_r <= 1'b1;
    end else if (kick_agree) begin
      kick_lvl_r <= kick_sync_r[2];
    end
  end

  // Output-good resets low, so reset stays asserted until it is seen high.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      good_sync_r <= 3'h0;
    end else begin
      good_sync_r <= {good_sync_r[1:0], regulated_output_good_i};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      good_lvl_r <= 1'b0;
    end else if (good_agree) begin
      good_lvl_r <= good_sync_r[2];
    end
  end

  // Base-unit tick divider, restarted on every state change.
  logic [TICK_W-1:0] tick_cnt_r;
  logic [TICK_W-1:0] tick_cnt_nxt;
  logic [UNIT_W-1:0] unit_cnt_r;
  logic [UNIT_W-1:0] unit_cnt_nxt;
  wwr_state_e        state_r;
  wwr_state_e        state_nxt;
  logic              kicked_r;
  logic              kicked_nxt;
  wwr_out_s          out_r;
  wwr_out_s          out_nxt;

  // True when the current unit is the last of an interval of n units.
  function automatic logic last_unit(input logic [UNIT_W-1:0] cnt,
                                     input logic [UNIT_W-1:0] n);
    last_unit = (cnt == n - 4'h1);
  endfunction : last_unit

  // One-cycle enable at the last system clock of each base unit.
  wire tick_end   = (tick_cnt_r == TICK_W'(BASE_CYC - 1)); // R14
  wire delay_end  = tick_end & last_unit(unit_cnt_r, RST_DELAY_UNITS); // R13
  wire lead_end   = tick_end & last_unit(unit_cnt_r, RST_TO_WAKE_UNITS);
  wire cycle_end  = tick_end & last_unit(unit_cnt_r, WAKE_PERIOD_UNITS);
  wire high_phase = (unit_cnt_r < WAKE_HIGH_UNITS); // R2

  // A new wake-up cycle after a kicked one restarts the counters as well.
  wire state_move = (state_nxt != state_r);
  wire cycle_roll = (state_r == ST_CYCLE) & (state_nxt == ST_CYCLE)
                    & cycle_end;
  wire restart    = state_move | cycle_roll;

  // Next-state decode.
  always_comb begin
    state_nxt  = state_r;
    kicked_nxt = kicked_r;
    out_nxt    = out_r;
    case (state_r)
      // Hold both outputs low until the output is good.
      ST_RESET: begin
        out_nxt = '{wake: 1'b0, reset_n: 1'b0}; // R11
        if (good_lvl_r) begin // R7 R9
          state_nxt = ST_DELAY;
        end
      end
      // Reset stays low for one base unit, then releases.
      ST_DELAY: begin
        out_nxt = '{wake: 1'b0, reset_n: 1'b0};
        if (delay_end) begin // R10
          state_nxt       = ST_LEAD;
          out_nxt.reset_n = 1'b1;
        end
      end
      // Wake-up stays low for four units after the release.
      ST_LEAD: begin
        out_nxt.wake = 1'b0;
        if (lead_end) begin // R12
          state_nxt    = ST_CYCLE;
          kicked_nxt   = 1'b0;
          out_nxt.wake = 1'b1;
        end
      end
      // A kick lowers wake-up until the cycle ends; later kicks do nothing.
      ST_CYCLE: begin
        if (kick_fall && !kicked_r) begin // R4 R5
          kicked_nxt = 1'b1;
        end
        out_nxt.wake = high_phase & ~kicked_nxt; // R1 R4
        if (cycle_end) begin
          if (!kicked_nxt) begin // R6
            state_nxt = ST_DELAY;
            out_nxt   = '{wake: 1'b0, reset_n: 1'b0};
          end else begin
            kicked_nxt   = 1'b0;
            out_nxt.wake = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = ST_RESET;
        out_nxt   = '{wake: 1'b0, reset_n: 1'b0};
      end
    endcase
    // Reset wins over every state while the output is not good.
    if (!good_lvl_r) begin // R8 R9
      state_nxt = ST_RESET;
      out_nxt   = '{wake: 1'b0, reset_n: 1'b0};
    end
  end

  // Counters clear on restart; the unit count steps at each tick.
  assign tick_cnt_nxt = (restart || tick_end) ? '0 : tick_cnt_r + 1'b1;
  assign unit_cnt_nxt = restart  ? '0 :
                        tick_end ? unit_cnt_r + 4'h1 :
                                   unit_cnt_r;

  // Supervisor state.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Tick divider of one base unit.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  // Base units elapsed in the current interval.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unit_cnt_r <= '0;
    end else begin
      unit_cnt_r <= unit_cnt_nxt;
    end
  end

  // Set by the first kick of a wake-up cycle.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kicked_r <= 1'b0;
    end else begin
      kicked_r <= kicked_nxt;
    end
  end

  // Output register; both ports come straight from it.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_r <= '{wake: 1'b0, reset_n: 1'b0};
    end else begin
      out_r <= out_nxt;
    end
  end

  assign wake_up_o = out_r.wake;
  assign reset_n_o = out_r.reset_n;

endmodule : wwr_supervisor

// *** wwr_pkg.sv ***
// Package for the wake-up, watchdog and reset supervisor.
// Assumes one 20 MHz system clock and a shared timebase tick counter.
package wwr_pkg;

  // System clock period in ns.
  localparam int unsigned CLK_PERIOD_NS   = 50;
  // Watchdog response time in ns and its cycle count (longest, round down).
  localparam int unsigned WDG_RESP_NS     = 2000;
  localparam int unsigned WDG_RESP_CYC    = WDG_RESP_NS / CLK_PERIOD_NS;

  // Timebase: one base unit in system clock cycles (5 ms reset delay).
  localparam int unsigned BASE_UNIT_US    = 5000;
  localparam int unsigned BASE_UNIT_CYC   =
    (BASE_UNIT_US * 1000) / CLK_PERIOD_NS;

  // Interval lengths in base units, ratio 8:1:4.
  localparam logic [3:0] WAKE_PERIOD_UNITS = 4'h8;
  localparam logic [3:0] WAKE_HIGH_UNITS   = 4'h4;
  localparam logic [3:0] RST_DELAY_UNITS   = 4'h1;
  localparam logic [3:0] RST_TO_WAKE_UNITS = 4'h4;

  localparam int unsigned TICK_W          = 20;
  localparam int unsigned UNIT_W          = 4;

  // Supervisor states.
  typedef enum logic [1:0] {
    ST_RESET  = 2'b00,
    ST_DELAY  = 2'b01,
    ST_LEAD   = 2'b10,
    ST_CYCLE  = 2'b11
  } wwr_state_e;

  // Output bundle.
  typedef struct packed {
    logic wake;
    logic reset_n;
  } wwr_out_s;

endpackage : wwr_pkg

// *** wwr_supervisor_monitor.sv ***
// Assertions on the supervisor ports.
// Assumes BASE_CYC matches the bound instance.
`timescale 1ns/100ps
module wwr_supervisor_monitor #(parameter int BASE_CYC = 10) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic watchdog_kick_input_i,
  input wire logic regulated_output_good_i,
  input wire logic wake_up_o,
  input wire logic reset_n_o
);
  localparam int A4 = 4*BASE_CYC-1, B4 = A4+2, A8 = 8*BASE_CYC-1, B8 = A8+2;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  chk_wake_in_rst: assert property (!reset_n_o && !$past(reset_n_o) |->
    !wake_up_o) else $error("wake");
  chk_uv_reset: assert property ((!regulated_output_good_i)[*8] |->
    !reset_n_o) else $error("undervoltage");
  chk_rel_delay: assert property ($rose(reset_n_o) |->
    $past(regulated_output_good_i, BASE_CYC) && !$past(reset_n_o, BASE_CYC))
    else $error("release");
  chk_lead_time: assert property ($rose(reset_n_o) |->
    ##[A4:B4] $rose(wake_up_o)) else $error("lead");
  chk_kick_resp: assert property ($fell(watchdog_kick_input_i) &&
    wake_up_o |-> ##[1:7] !wake_up_o) else $error("kick");
  chk_low_hold: assert property ($fell(wake_up_o) |->
    (!wake_up_o)[*8]) else $error("hold");
  chk_half_high: assert property ($rose(wake_up_o) |->
    ##[A4:B4] !wake_up_o) else $error("half");
  chk_cycle_end: assert property ($rose(wake_up_o) |->
    ##[A8:B8] (wake_up_o || !reset_n_o)) else $error("cycle");
endmodule : wwr_supervisor_monitor
bind wwr_supervisor wwr_supervisor_monitor #(.BASE_CYC(BASE_CYC)) mon_inst (
  .clk_sys_i              (clk_sys_i),
  .rst_n_i                (rst_n_i),
  .watchdog_kick_input_i  (watchdog_kick_input_i),
  .regulated_output_good_i(regulated_output_good_i),
  .wake_up_o              (wake_up_o),
  .reset_n_o              (reset_n_o)
);

// *** wwr_cpu_model.sv ***
// Processor model: two kicks after each wake rise unless skip_i is high.
// Assumes the bench seeds the random generator.
`timescale 1ns/100ps
module wwr_cpu_model (
  input  wire logic clk_i,
  input  wire logic wake_i,
  input  wire logic skip_i,
  output logic      kick_o = 1'b1
);
  always @(posedge wake_i) begin
    if (!skip_i) begin
      repeat ($urandom_range(30, 1)) @(negedge clk_i);
      repeat (2) begin
        kick_o = 1'b0;
        repeat (2) @(negedge clk_i);
        kick_o = 1'b1;
        repeat (6) @(negedge clk_i);
      end
    end
  end
endmodule : wwr_cpu_model

// *** wwr_supervisor_tb.sv ***
// Random bench of the supervisor with a processor model.
// Assumes a base count shortened to ten clocks.
`timescale 1ns/100ps
module wwr_supervisor_tb;
  localparam int B = 10;
  logic clk = 1'b0, rst_n_i = 1'b0, good = 1'b0, skip = 1'b0;
  logic s, kick, wake, rst_n;
  int n_mismatch = 0, comparisons = 0, n;
  always #25 clk = ~clk;
  wwr_supervisor #(.BASE_CYC(B)) wwr_supervisor_inst (.clk_sys_i(clk),
    .rst_n_i, .watchdog_kick_input_i(kick), .regulated_output_good_i(good),
    .wake_up_o(wake), .reset_n_o(rst_n));
  wwr_cpu_model wwr_cpu_model_inst (.clk_i(clk), .wake_i(wake),
    .skip_i(skip), .kick_o(kick));
  task automatic check(logic [7:0] seen, exp, string what);
    comparisons++;
    n_mismatch += (seen !== exp);
    if (seen !== exp) $display("Error %s exp %0h seen %0h", what, exp, seen);
  endtask : check
  function automatic int units(int u);
    return u * B;
  endfunction : units
  task automatic till(bit w, logic v, output int c);
    for (c = 0; (w ? wake : rst_n) !== v && c < 999; c++) @(negedge clk);
  endtask : till
  task automatic summarize(int extra);
    n_mismatch += extra;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  initial #(units(400) * 50) summarize(1);
  initial begin
    void'($urandom(54085));
    repeat (2) @(negedge clk);
    rst_n_i = 1'b1;
    repeat (20) @(negedge clk);
    check(rst_n, 0, "power-up");
    good = 1'b1;
    till(0, 1, n);
    till(1, 1, n);
    check(n >= units(4) - 2 && n <= units(4) + 6, 1, "lead");
    for (int i = 0; i < 8; i++) begin
      s = skip;
      skip = i == 1 || $urandom_range(2) == 0;
      till(1, 0, n);
      till(1, 1, n);
      check(n > units(8), s, "missed kick");
    end
    good = 1'b0;
    repeat (99) @(negedge clk);
    check({rst_n, wake}, 0, "undervoltage");
    summarize(0);
  end
endmodule : wwr_supervisor_tb
